// File: hw/sadc_frame_ctrl.sv
// frame control of a 14-bit successive-approximation converter
// assumes a host drives cs_b and sclk; adc_code is the analog core's
// comparator result, stable on the core clock; sdo is resolved outside
`timescale 1ns/1ps
`include "sadc_defines.svh"

module sadc_frame_ctrl #(
    parameter int CODE_W = `SADC_CODE_W,
    parameter int ACQ_CYC = `SADC_MIN_ACQ_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic [CODE_W-1:0] adc_code,
    output logic sdo,
    output logic sdo_oe_b,
    output sadc_pkg::sadc_state_t state,
    output logic acq_ready
);
    import sadc_pkg::*;

    sadc_ctrl_t ctrl_reg; // all core-side state
    sadc_ctrl_t ctrl_next; // next value
    logic link_conv; // eighteen falls seen, link domain
    logic link_pcal; // twenty-four falls seen, link domain
    logic link_rcal; // sixty-four falls seen, link domain
    logic cs_fall; // frame opens
    logic cs_rise; // frame closes
    logic conv_hit; // conversion clocks arrived
    logic cal_hit; // calibration clocks arrived

    // filter: a change counts once second and third stages agree
    function automatic logic filt(input logic [2:0] s, input logic cur);
        filt = (s[1] == s[2]) ? s[2] : cur;
    endfunction

    // link side shifter; result word only changes away from the data bits
    sadc_link_shift #(
        .CODE_W(CODE_W)
    ) u_link (
        .sclk(sclk),
        .cs_b(cs_b),
        .result(ctrl_reg.result),
        .sdo(sdo),
        .reach_conv(link_conv),
        .reach_pwrup_cal(link_pcal),
        .reach_run_cal(link_rcal)
    );

    // next state of the core side
    always_comb begin
        ctrl_next = ctrl_reg;
        // three-stage synchronisers; stage 0 feeds only stage 1
        ctrl_next.cs_sync = {ctrl_reg.cs_sync[1:0], cs_b};
        ctrl_next.conv_sync = {ctrl_reg.conv_sync[1:0], link_conv};
        ctrl_next.pcal_sync = {ctrl_reg.pcal_sync[1:0], link_pcal};
        ctrl_next.rcal_sync = {ctrl_reg.rcal_sync[1:0], link_rcal};
        ctrl_next.cs_lvl = filt(ctrl_reg.cs_sync, ctrl_reg.cs_lvl);
        ctrl_next.conv_lvl = filt(ctrl_reg.conv_sync, ctrl_reg.conv_lvl);
        ctrl_next.pcal_lvl = filt(ctrl_reg.pcal_sync, ctrl_reg.pcal_lvl);
        ctrl_next.rcal_lvl = filt(ctrl_reg.rcal_sync, ctrl_reg.rcal_lvl);
        // frame edges and threshold arrivals
        cs_fall = ctrl_reg.cs_lvl && !ctrl_next.cs_lvl;
        cs_rise = !ctrl_reg.cs_lvl && ctrl_next.cs_lvl;
        conv_hit = !ctrl_reg.conv_lvl && ctrl_next.conv_lvl;
        if (ctrl_reg.first_frame) begin
            cal_hit = !ctrl_reg.pcal_lvl && ctrl_next.pcal_lvl;
        end else begin
            cal_hit = !ctrl_reg.rcal_lvl && ctrl_next.rcal_lvl;
        end
        // output released whenever the filtered select is high
        ctrl_next.oe_b = ctrl_next.cs_lvl;
        // state moves only on host select and clock activity
        unique case (ctrl_reg.state)
            acquisition_state: begin
                if (cs_fall) begin
                    ctrl_next.state = conversion_state;
                end
            end
            conversion_state: begin
                if (conv_hit) begin
                    // code is stored unsigned, as the core gives it
                    ctrl_next.result = adc_code;
                    ctrl_next.state = acquisition_state;
                end else if (cs_rise) begin
                    ctrl_next.result = `SADC_INVALID_CODE;
                    ctrl_next.state = acquisition_state;
                end
            end
            offset_calibration_state: begin
                if (cs_rise) begin
                    ctrl_next.state = acquisition_state;
                end
            end
        endcase
        // calibration entered once its clock count arrives in the frame;
        // a frame closing earlier leaves the state in acquisition
        if (cal_hit && !ctrl_next.cs_lvl) begin
            ctrl_next.state = offset_calibration_state;
        end
        // power-up frame is over once select rises
        if (cs_rise) begin
            ctrl_next.first_frame = 1'b0;
        end
        // acquisition time counter, restarted on leaving acquisition
        if (ctrl_next.state != acquisition_state) begin
            ctrl_next.acq_cnt = '0;
        end else if (ctrl_reg.acq_cnt != `SADC_ACQ_CNT_W'(ACQ_CYC)) begin
            ctrl_next.acq_cnt = ctrl_reg.acq_cnt + 1'b1;
        end
        ctrl_next.acq_ready = (ctrl_next.state == acquisition_state) &&
            (ctrl_next.acq_cnt == `SADC_ACQ_CNT_W'(ACQ_CYC));
    end

    // register the state; reset stands for power-up
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_reg <= '0;
            ctrl_reg.cs_sync <= 3'h7;
            ctrl_reg.cs_lvl <= 1'b1;
            ctrl_reg.oe_b <= 1'b1;
            ctrl_reg.state <= acquisition_state;
            ctrl_reg.first_frame <= 1'b1;
            ctrl_reg.result <= `SADC_FIRST_RESULT;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // outputs straight from flops
    assign sdo_oe_b = ctrl_reg.oe_b;
    assign state = ctrl_reg.state;
    assign acq_ready = ctrl_reg.acq_ready;

    // ---- checks ----

    // frame opening and closing as seen by the core
    sequence s_open;
        ctrl_reg.cs_lvl && !ctrl_next.cs_lvl;
    endsequence

    sequence s_close;
        !ctrl_reg.cs_lvl && ctrl_next.cs_lvl;
    endsequence

    // conversion clocks reach the core while converting
    sequence s_conv_done;
        ctrl_reg.state == conversion_state && !ctrl_reg.conv_lvl && ctrl_next.conv_lvl;
    endsequence

    // a frame that closes while still converting
    sequence s_short_frame;
        ctrl_reg.state == conversion_state && !ctrl_next.conv_lvl ##0 s_close;
    endsequence

    // acquisition follows release of reset
    property p_pwrup_acq;
        @(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> (state == acquisition_state) && ctrl_reg.first_frame;
    endproperty
    a_pwrup_acq: assert property (p_pwrup_acq) else $error("not acquiring after reset");

    // output stays released while select is settled high
    property p_release;
        @(posedge clk) disable iff (!rst_b)
        ctrl_reg.cs_sync[2] && ctrl_reg.cs_sync[1] |=> sdo_oe_b;
    endproperty
    a_release: assert property (p_release) else $error("output driven with select high");

    // opening edge in acquisition starts conversion
    property p_open_conv;
        @(posedge clk) disable iff (!rst_b)
        (state == acquisition_state) ##0 s_open |=> (state == conversion_state) && !sdo_oe_b;
    endproperty
    a_open_conv: assert property (p_open_conv) else $error("open did not convert");

    // conversion end stores the code and goes back to acquiring
    property p_conv_end;
        @(posedge clk) disable iff (!rst_b)
        s_conv_done |=> (ctrl_reg.result == $past(adc_code)) &&
            (state != conversion_state);
    endproperty
    a_conv_end: assert property (p_conv_end) else $error("conversion end mishandled");

    // calibration left on frame close
    property p_cal_exit;
        @(posedge clk) disable iff (!rst_b)
        (state == offset_calibration_state) ##0 s_close |=> state == acquisition_state;
    endproperty
    a_cal_exit: assert property (p_cal_exit) else $error("calibration not left");

    // word stays zero from power-up until the first conversion stores one
    property p_first_zero;
        @(posedge clk) disable iff (!rst_b)
        ctrl_reg.first_frame && (ctrl_reg.cs_lvl || (state == conversion_state)) |->
            ctrl_reg.result == `SADC_FIRST_RESULT;
    endproperty
    a_first_zero: assert property (p_first_zero) else $error("first word not zero");

    // short frame replaces the next word with the invalid code
    property p_short_invalid;
        @(posedge clk) disable iff (!rst_b)
        s_short_frame |=> (ctrl_reg.result == `SADC_INVALID_CODE) &&
            (state == acquisition_state);
    endproperty
    a_short_invalid: assert property (p_short_invalid) else $error("short frame kept code");

    // power-up calibration entered only in the first frame
    property p_pwrup_cal;
        @(posedge clk) disable iff (!rst_b)
        ctrl_reg.first_frame && !ctrl_reg.pcal_lvl && ctrl_next.pcal_lvl &&
            !ctrl_next.cs_lvl |=> state == offset_calibration_state;
    endproperty
    a_pwrup_cal: assert property (p_pwrup_cal) else $error("power-up calibration missed");

    // run-time calibration entered at sixty-four clocks
    property p_run_cal;
        @(posedge clk) disable iff (!rst_b)
        !ctrl_reg.first_frame && !ctrl_reg.rcal_lvl && ctrl_next.rcal_lvl &&
            !ctrl_next.cs_lvl |=> state == offset_calibration_state;
    endproperty
    a_run_cal: assert property (p_run_cal) else $error("run calibration missed");

    // any frame close ends in acquisition, so aborted calibrations too
    property p_close_acq;
        @(posedge clk) disable iff (!rst_b)
        s_close |=> state == acquisition_state [*2];
    endproperty
    a_close_acq: assert property (p_close_acq) else $error("not acquiring after close");

    // acquisition ready only after the minimum time in acquisition
    property p_acq_time;
        @(posedge clk) disable iff (!rst_b)
        $rose(acq_ready) |-> ($past(state) == acquisition_state) &&
            (ctrl_reg.acq_cnt == `SADC_ACQ_CNT_W'(ACQ_CYC));
    endproperty
    a_acq_time: assert property (p_acq_time) else $error("acquisition time short");
endmodule

// File: shared/sadc_defines.svh
// constants for the serial frame control of the 14-bit converter
// assumes nothing; included by the package and by both design files
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// result word width and frame clock thresholds
`define SADC_CODE_W 14
`define SADC_FALL_CNT_W 7
`define SADC_CONV_FALLS 18
`define SADC_PWRUP_CAL_CLKS 24
`define SADC_RUN_CAL_CLKS 64
`define SADC_LAST_DATA_FALL 14

// straight binary code points
`define SADC_NEG_FULL_SCALE_CODE 14'h0000
`define SADC_MID_SCALE_CODE 14'h1FFF
`define SADC_POS_FULL_SCALE_CODE 14'h3FFF
`define SADC_FIRST_RESULT 14'h0000
`define SADC_INVALID_CODE 14'h0000

// minimum acquisition time and its cycle count at the core clock
`define SADC_CLK_MHZ 50
`define SADC_MIN_ACQ_NS 230
`define SADC_MIN_ACQ_CYC ((`SADC_MIN_ACQ_NS * `SADC_CLK_MHZ + 999) / 1000)
`define SADC_ACQ_CNT_W 8

`endif

// File: shared/sadc_pkg.sv
// types shared by the frame controller and its link-side shifter
// assumes the defines header is on the include path
`include "sadc_defines.svh"

package sadc_pkg;

    // the three operating states
    typedef enum logic [1:0] {
        acquisition_state,
        conversion_state,
        offset_calibration_state
    } sadc_state_t;

    // link-side state, clocked by the serial clock
    typedef struct packed {
        logic [`SADC_FALL_CNT_W-1:0] falls; // falling edges this frame
        logic reach_conv; // conversion clocks seen
        logic reach_pwrup_cal; // power-up calibration clocks seen
        logic reach_run_cal; // run-time calibration clocks seen
    } sadc_link_t;

    // core-side state, clocked by clk
    typedef struct packed {
        logic [2:0] cs_sync; // chip select synchroniser
        logic [2:0] conv_sync; // conversion flag synchroniser
        logic [2:0] pcal_sync; // power-up calibration flag synchroniser
        logic [2:0] rcal_sync; // run calibration flag synchroniser
        logic cs_lvl; // filtered chip select
        logic conv_lvl; // filtered conversion flag
        logic pcal_lvl; // filtered power-up calibration flag
        logic rcal_lvl; // filtered run calibration flag
        sadc_state_t state; // operating state
        logic first_frame; // no frame closed since power-up
        logic [`SADC_CODE_W-1:0] result; // word for the next frame
        logic oe_b; // output enable, low drives
        logic [`SADC_ACQ_CNT_W-1:0] acq_cnt; // cycles spent acquiring
        logic acq_ready; // minimum acquisition time met
    } sadc_ctrl_t;

endpackage

// File: hw/sadc_link_shift.sv
// serial clock side: counts falling edges and launches result bits
// assumes cs_b high clears the frame; the clock stands still outside frames
`timescale 1ns/1ps
`include "sadc_defines.svh"

module sadc_link_shift #(
    parameter int CODE_W = `SADC_CODE_W
) (
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic [CODE_W-1:0] result,
    output logic sdo,
    output logic reach_conv,
    output logic reach_pwrup_cal,
    output logic reach_run_cal
);
    import sadc_pkg::*;

    sadc_link_t link_reg; // counter and threshold flags
    sadc_link_t link_next; // next value
    logic sdo_reg; // launched data bit
    logic sdo_next; // bit for the coming rising edge

    // count falling edges, saturating, and raise threshold flags
    always_comb begin
        link_next = link_reg;
        if (link_reg.falls != `SADC_FALL_CNT_W'(`SADC_RUN_CAL_CLKS)) begin
            link_next.falls = link_reg.falls + 1'b1;
        end
        link_next.reach_conv = link_next.falls >= `SADC_FALL_CNT_W'(`SADC_CONV_FALLS);
        link_next.reach_pwrup_cal =
            link_next.falls >= `SADC_FALL_CNT_W'(`SADC_PWRUP_CAL_CLKS);
        link_next.reach_run_cal = link_next.falls >= `SADC_FALL_CNT_W'(`SADC_RUN_CAL_CLKS);
    end

    // frame state lives only while chip select is low
    always_ff @(negedge sclk or posedge cs_b) begin
        if (cs_b) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    // msb after first fall, then one bit per rising edge, then zeros
    always_comb begin
        sdo_next = 1'b0;
        if (link_reg.falls >= 1 && link_reg.falls <= `SADC_LAST_DATA_FALL) begin
            sdo_next = result[CODE_W - int'(link_reg.falls)];
        end
    end

    // leading zero comes from the clear while chip select is high
    always_ff @(posedge sclk or posedge cs_b) begin
        if (cs_b) begin
            sdo_reg <= 1'b0;
        end else begin
            sdo_reg <= sdo_next;
        end
    end

    assign sdo = sdo_reg;
    assign reach_conv = link_reg.reach_conv;
    assign reach_pwrup_cal = link_reg.reach_pwrup_cal;
    assign reach_run_cal = link_reg.reach_run_cal;

    // msb launched on the rising edge after the first fall
    property p_msb_first;
        @(posedge sclk) disable iff (cs_b)
        (link_reg.falls == 1) |=> (sdo_reg == $past(result[CODE_W-1]));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb not launched first");

    // zeros once all data bits have gone
    property p_tail_zero;
        @(posedge sclk) disable iff (cs_b)
        (link_reg.falls > `SADC_LAST_DATA_FALL) |=> !sdo_reg;
    endproperty
    a_tail_zero: assert property (p_tail_zero) else $error("nonzero after last bit");
endmodule

// File: sim/sadc_host_model.sv
// host controller model: drives chip select and the serial clock
// assumes the bench resolves the data pin from the device's enable
`timescale 1ns/1ps

module sadc_host_model #(
    parameter int HALF_NS = 24
) (
    output logic cs_b,
    output logic sclk,
    input wire logic sdo_pin
);
    // data pin level seen just before each falling edge, by fall number
    logic [64:1] seen;

    // idle: deselected, clock parked high, no edges outside frames
    initial begin
        cs_b = 1'b0;
        sclk = 1'b1;
        seen = '0;
        // a select rise just after power-up clears the link logic
        #1;
        cs_b = 1'b1;
    end

    // one frame of n falling edges; the clock stands still around it
    task automatic run_frame(input int n);
        cs_b = 1'b0;
        #120;
        // the host paces conversion and shifting alike
        for (int k = 1; k <= n; k++) begin
            seen[k] = sdo_pin;
            sclk = 1'b0;
            #HALF_NS;
            sclk = 1'b1;
            #HALF_NS;
        end
        // leave time for the core to see the last counts before closing
        #150;
        cs_b = 1'b1;
        // deselect gap long enough for the core filters
        #120;
    endtask
endmodule

// File: sim/sadc_frame_ctrl_tb_top.sv
// self-checking bench for the converter frame control
// assumes the host model paces frames; the bench watches the core clock
`timescale 1ns/1ps
`include "sadc_defines.svh"

module sadc_frame_ctrl_tb_top;
    import sadc_pkg::*;

    logic clk; // core clock
    logic rst_b; // power-up stand-in
    logic [`SADC_CODE_W-1:0] adc_code; // analog core result
    wire cs_b; // from host
    wire sclk; // from host
    logic sdo; // raw data
    logic sdo_oe_b; // low while driving
    sadc_state_t state;
    logic acq_ready;
    wire sdo_pin; // resolved data pin
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 54413;
    logic saw_cal; // calibration state seen in this frame
    logic [13:0] exp_q [$]; // words the coming frames must carry
    logic first_frame; // no frame since reset
    int falls_tab [8] = '{18, 17, 18, 10, 40, 64, 18, 30};
    logic [13:0] code_tab [4] = '{`SADC_POS_FULL_SCALE_CODE, `SADC_MID_SCALE_CODE,
        14'h2000, `SADC_NEG_FULL_SCALE_CODE};

    // pin released while the enable is high
    assign sdo_pin = sdo_oe_b ? 1'bz : sdo;

    sadc_frame_ctrl #(.CODE_W(`SADC_CODE_W), .ACQ_CYC(`SADC_MIN_ACQ_CYC)) dut (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .adc_code(adc_code),
        .sdo(sdo), .sdo_oe_b(sdo_oe_b), .state(state), .acq_ready(acq_ready));

    sadc_host_model host (.cs_b(cs_b), .sclk(sclk), .sdo_pin(sdo_pin));

    // core clock, 20 ns
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // watchdog and calibration watch
    always @(posedge clk) begin
        cycles++;
        if (state === offset_calibration_state) saw_cal = 1'b1;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one comparison, counted
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [13:0] rnd14();
        int r;
        r = $random(seed);
        return r[13:0];
    endfunction

    // synchronous reset for ten cycles, then let the filters fill
    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        exp_q.delete();
        exp_q.push_back(`SADC_FIRST_RESULT);
        first_frame = 1'b1;
        @(negedge clk);
        chk("state after reset", {14'h0, acquisition_state}, {14'h0, state});
        chk("enable after reset", 16'h1, {15'h0, sdo_oe_b});
    endtask

    // one frame of n falls with the analog core holding code
    task automatic frame(input int n, input logic [13:0] code);
        logic [13:0] want;
        logic exp_bit;
        logic exp_cal;
        int w;
        want = exp_q.pop_front();
        exp_cal = first_frame ? (n >= 24) : (n >= 64);
        @(posedge clk);
        adc_code <= code;
        // host waits out the acquisition time, sampling away from the edge
        w = 0;
        @(negedge clk);
        while (acq_ready !== 1'b1 && w < 100) begin
            @(negedge clk);
            w++;
        end
        chk("ready before frame", 16'h1, {15'h0, acq_ready});
        #(($random(seed) & 15) + 1);
        saw_cal = 1'b0;
        fork
            host.run_frame(n);
            begin
                #100;
                @(negedge clk);
                chk("state in frame", {14'h0, conversion_state}, {14'h0, state});
                chk("enable in frame", 16'h0, {15'h0, sdo_oe_b});
            end
        join
        @(negedge clk);
        chk("state after frame", {14'h0, acquisition_state}, {14'h0, state});
        chk("calibration seen", {15'h0, exp_cal}, {15'h0, saw_cal});
        chk("pin released", {15'h0, 1'bz}, {15'h0, sdo_pin});
        chk("data idle", 16'h0, {15'h0, sdo});
        // leading zero, then the word msb first, then zeros
        for (int k = 1; k <= n; k++) begin
            exp_bit = (k >= 2 && k <= 15) ? want[15 - k] : 1'b0;
            chk("sdo bit", {15'h0, exp_bit}, {15'h0, host.seen[k]});
        end
        // short frames leave an invalid word behind
        exp_q.push_back((n >= `SADC_CONV_FALLS) ? code : `SADC_INVALID_CODE);
        first_frame = 1'b0;
    endtask

    // main sequence
    initial begin
        rst_b = 1'b0;
        adc_code = '0;
        saw_cal = 1'b0;
        exp_q.delete();
        first_frame = 1'b1;
        do_reset();
        frame(20, rnd14());
        // boundary fall counts and the code points
        for (int i = 0; i < 8; i++) begin
            frame(falls_tab[i], (i < 4) ? code_tab[i] : rnd14());
        end
        repeat (6) frame(18 + ($random(seed) & 31), rnd14());
        // second power-up with calibration in its first frame
        do_reset();
        frame(24, rnd14());
        frame(18, rnd14());
        frame(64, rnd14());
        frame(18, rnd14());
        give_verdict();
    end
endmodule
